// ===== hlt_ext_src.sv
// model of the on-chip logic that drives the external reset signal
// assumes the bench commands a level; the pin changes just after a rising edge
module hlt_ext_src (
    input  wire logic clk,
    input  wire logic lvl,
    output logic      ext_reset_signal
);
    timeunit 1ns;
    timeprecision 1ps;
    // a plain logic output, never released: it shows the level commanded at the last rising edge
    initial ext_reset_signal = 1'b0;
    always @(posedge clk) begin
        ext_reset_signal <= lvl;
    end
endmodule // hlt_ext_src

// ===== hlt_params.svh
// constants for the hardware limit timer mode control
// assumes an 8-bit count and a 5-bit mode field
`ifndef HLT_PARAMS_SVH
`define HLT_PARAMS_SVH

`define HLT_CNT_W      8
`define HLT_MODE_W     5
`define HLT_CNT_ZERO   8'h00
`define HLT_CNT_ONE    8'h01
`define HLT_SYNC_RST   2'h0

// free-running period modes
`define HLT_M_SW_GATE  5'h00
`define HLT_M_GATE_HI  5'h01
`define HLT_M_GATE_LO  5'h02
`define HLT_M_RST_ANY  5'h03
`define HLT_M_RST_RISE 5'h04
`define HLT_M_RST_FALL 5'h05
`define HLT_M_RST_LOW  5'h06
`define HLT_M_RST_HIGH 5'h07
// one-shot modes
`define HLT_M_OS_SW    5'h08
`define HLT_M_OS_RISE  5'h09
`define HLT_M_OS_FALL  5'h0A
`define HLT_M_OS_ANY   5'h0B
`define HLT_M_OS_RR    5'h0C
`define HLT_M_OS_FF    5'h0D
`define HLT_M_OS_RLOW  5'h0E
`define HLT_M_OS_FHIGH 5'h0F
// monostable and level one-shot modes
`define HLT_M_MS_RISE  5'h11
`define HLT_M_MS_FALL  5'h12
`define HLT_M_MS_ANY   5'h13
`define HLT_M_LV_HIGH  5'h16
`define HLT_M_LV_LOW   5'h17

`endif

// ===== hlt_pkg.sv
// types shared by the timer mode control files
// assumes hlt_params.svh is on the include path
`include "hlt_params.svh"

package hlt_pkg;

    typedef logic [`HLT_CNT_W-1:0]  hlt_cnt_t;
    typedef logic [`HLT_MODE_W-1:0] hlt_mode_t;

    typedef struct packed {
        hlt_mode_t mode;
        hlt_cnt_t  period_value;
        hlt_cnt_t  pulse_width_compare;
        logic      pwm_en;
    } hlt_cfg_t;

    typedef struct packed {
        logic     on;
        logic     run;
        logic     prev;
        logic     match;
        hlt_cnt_t count;
    } hlt_state_t;

    typedef struct packed {
        logic [1:0] ff;
    } hlt_sync_t;

    typedef struct packed {
        logic out;
    } hlt_pwm_t;

endpackage

// ===== hlt_pwm.sv
// pulse-width output stage driven by the timer
// assumes set and clr are same-clock strobes from the timer
module hlt_pwm (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic en,
    input  wire logic set,
    input  wire logic clr,
    output logic      pwm_out
);

    hlt_pkg::hlt_pwm_t st_r;
    hlt_pkg::hlt_pwm_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (!en) begin
            st_nxt.out = 1'b0;
        end else if (set) begin
            st_nxt.out = 1'b1;
        end else if (clr) begin
            st_nxt.out = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r.out <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pwm_out = st_r.out;

endmodule // hlt_pwm

// ===== hlt_sync.sv
// two-flop synchroniser for the external reset signal
// assumes the input is asynchronous to clk
`include "hlt_params.svh"

module hlt_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);

    hlt_pkg::hlt_sync_t st_r;
    hlt_pkg::hlt_sync_t st_nxt;

    always_comb begin
        st_nxt.ff = {st_r.ff[0], din};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r.ff <= `HLT_SYNC_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // only the second flop is read outside
    assign dout = st_r.ff[1];

endmodule // hlt_sync

// ===== hlt_timer.sv
// period timer with hardware limit: mode decode, counter, enable handling
// assumes ext_reset_signal is asynchronous; cfg and strobes are on clk
//
// Notes on behaviour
// RQ1 - mode 00000: count while enable set, stop when software clears it
// RQ2 - mode 00001: count while enabled and external signal high
// RQ3 - mode 00010: count while enabled and external signal low
// RQ4 - mode 00011: either external edge clears the count, runs until disabled
// RQ5 - modes 00100/00101: rising or falling edge clears the count
// RQ6 - modes 00110/00111: count held reset while signal low or high
// RQ7 - mode 01000: one-shot starts as soon as enable is set
// RQ8 - modes 01001-01011: one-shot starts on rising, falling or any edge
// RQ9 - mode 01100: rising edge starts, later rising edge clears count
// RQ10 - mode 01101: falling edge starts, later falling edge clears count
// RQ11 - modes 01110/01111: held at reset level, start on transition away
// RQ12 - one-shot: clock after period match clears enable, count to 00h
// RQ13 - modes 10001-10011 monostable edge start; 10000 reserved
// RQ14 - monostable: clock after match stops at 00h, enable stays set
// RQ15 - modes 10110/10111: start on high or low level, opposite level resets
// RQ16 - edge-started modes need a fresh edge after re-enabling
// RQ17 - level-reset one-shot: pulse output goes active on starting edge
// RQ18 - pulse output goes inactive when count equals compare value
// RQ19 - level-reset one-shot: pulse output not set again when count clears on period match
// RQ20 - reserved codes leave the counter stopped, never started
// RQ21 - edges found by comparing synchronised current and previous samples
`include "hlt_params.svh"

module hlt_timer (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire hlt_pkg::hlt_cfg_t cfg,
    input  wire logic          on_set,
    input  wire logic          on_clr,
    input  wire logic          ext_reset_signal,
    output hlt_pkg::hlt_cnt_t  count_value,
    output logic               enable_status,
    output logic               period_match,
    output logic               pwm_out
);

    hlt_pkg::hlt_state_t st_r;
    hlt_pkg::hlt_state_t st_nxt;

    logic ext_s;
    logic rise;
    logic fall;
    logic gate;
    logic use_run;
    logic start;
    logic edge_rst;
    logic lvl_rst;
    logic one_shot;
    logic mono;
    logic rsv;
    logic lvl_pwm;
    logic active;
    logic match;
    logic pwm_set;
    logic pwm_clr;

    hlt_sync u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (ext_reset_signal),
        .dout (ext_s)
    );

    // edge detect on synchronised samples
    assign rise = ext_s & ~st_r.prev; // RQ21
    assign fall = ~ext_s & st_r.prev; // RQ21

    // mode decode
    always_comb begin
        gate     = 1'b0;
        use_run  = 1'b1;
        start    = 1'b0;
        edge_rst = 1'b0;
        lvl_rst  = 1'b0;
        one_shot = 1'b0;
        mono     = 1'b0;
        rsv      = 1'b0;
        lvl_pwm  = 1'b0;
        case (cfg.mode)
            `HLT_M_SW_GATE: begin
                use_run = 1'b0;
                gate    = st_r.on; // RQ1
            end
            `HLT_M_GATE_HI: begin
                use_run = 1'b0;
                gate    = st_r.on & ext_s; // RQ2
            end
            `HLT_M_GATE_LO: begin
                use_run = 1'b0;
                gate    = st_r.on & ~ext_s; // RQ3
            end
            `HLT_M_RST_ANY: begin
                use_run  = 1'b0;
                gate     = st_r.on;
                edge_rst = rise | fall; // RQ4
            end
            `HLT_M_RST_RISE: begin
                use_run  = 1'b0;
                gate     = st_r.on;
                edge_rst = rise; // RQ5
            end
            `HLT_M_RST_FALL: begin
                use_run  = 1'b0;
                gate     = st_r.on;
                edge_rst = fall; // RQ5
            end
            `HLT_M_RST_LOW: begin
                use_run = 1'b0;
                gate    = st_r.on & ext_s;
                lvl_rst = ~ext_s; // RQ6
            end
            `HLT_M_RST_HIGH: begin
                use_run = 1'b0;
                gate    = st_r.on & ~ext_s;
                lvl_rst = ext_s; // RQ6
            end
            `HLT_M_OS_SW: begin
                one_shot = 1'b1;
                start    = 1'b1; // RQ7
            end
            `HLT_M_OS_RISE: begin
                one_shot = 1'b1;
                start    = rise; // RQ8
            end
            `HLT_M_OS_FALL: begin
                one_shot = 1'b1;
                start    = fall; // RQ8
            end
            `HLT_M_OS_ANY: begin
                one_shot = 1'b1;
                start    = rise | fall; // RQ8
            end
            `HLT_M_OS_RR: begin
                one_shot = 1'b1;
                start    = rise; // RQ9
                edge_rst = rise & st_r.run; // RQ9
            end
            `HLT_M_OS_FF: begin
                one_shot = 1'b1;
                start    = fall; // RQ10
                edge_rst = fall & st_r.run; // RQ10
            end
            `HLT_M_OS_RLOW: begin
                one_shot = 1'b1;
                lvl_pwm  = 1'b1;
                start    = rise; // RQ11
                lvl_rst  = ~ext_s; // RQ11
            end
            `HLT_M_OS_FHIGH: begin
                one_shot = 1'b1;
                lvl_pwm  = 1'b1;
                start    = fall; // RQ11
                lvl_rst  = ext_s; // RQ11
            end
            `HLT_M_MS_RISE: begin
                mono  = 1'b1;
                start = rise; // RQ13
            end
            `HLT_M_MS_FALL: begin
                mono  = 1'b1;
                start = fall; // RQ13
            end
            `HLT_M_MS_ANY: begin
                mono  = 1'b1;
                start = rise | fall; // RQ13
            end
            `HLT_M_LV_HIGH: begin
                one_shot = 1'b1;
                start    = ext_s; // RQ15
                lvl_rst  = ~ext_s; // RQ15
            end
            `HLT_M_LV_LOW: begin
                one_shot = 1'b1;
                start    = ~ext_s; // RQ15
                lvl_rst  = ext_s; // RQ15
            end
            default: begin
                rsv = 1'b1; // RQ20
            end
        endcase
    end

    // counting condition and period match
    assign active = use_run ? (st_r.run & st_r.on & ~rsv) : gate;
    assign match  = active & (st_r.count == cfg.period_value);

    always_comb begin
        st_nxt       = st_r;
        st_nxt.prev  = ext_s;
        st_nxt.match = match & ~lvl_rst & ~edge_rst;
        // start only from idle: edges before enable are not remembered
        if (rsv || !use_run || !st_r.on) begin
            st_nxt.run = 1'b0; // RQ16 RQ20
        end else if (start && !st_r.run && !lvl_rst) begin
            st_nxt.run = 1'b1; // RQ7 RQ8 RQ16
        end
        if (lvl_rst) begin
            st_nxt.count = `HLT_CNT_ZERO; // RQ6 RQ11 RQ15
            if (use_run) begin
                st_nxt.run = 1'b0;
            end
        end else if (edge_rst && st_r.on) begin
            st_nxt.count = `HLT_CNT_ZERO; // RQ4 RQ5 RQ9 RQ10
        end else if (match) begin
            st_nxt.count = `HLT_CNT_ZERO; // RQ12 RQ14
            if (one_shot || mono) begin
                st_nxt.run = 1'b0; // RQ12 RQ14
            end
        end else if (active) begin
            st_nxt.count = st_r.count + `HLT_CNT_ONE;
        end
        // software set wins over any clear
        if (on_set) begin
            st_nxt.on = 1'b1;
        end else if (on_clr || (match && one_shot && !lvl_rst)) begin
            st_nxt.on = 1'b0; // RQ1 RQ12
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r.on    <= 1'b0;
            st_r.run   <= 1'b0;
            st_r.prev  <= 1'b0;
            st_r.match <= 1'b0;
            st_r.count <= `HLT_CNT_ZERO;
        end else begin
            st_r <= st_nxt;
        end
    end

    // pulse output: starting edge in level-reset one-shot, else period match or edge clear
    always_comb begin
        if (lvl_pwm) begin
            pwm_set = start & st_r.on & ~st_r.run & ~lvl_rst; // RQ17 RQ19
        end else begin
            pwm_set = match | (edge_rst & st_r.on);
        end
        pwm_clr = st_r.count == cfg.pulse_width_compare; // RQ18
    end

    hlt_pwm u_pwm (
        .clk     (clk),
        .rst     (rst),
        .en      (cfg.pwm_en),
        .set     (pwm_set),
        .clr     (pwm_clr),
        .pwm_out (pwm_out)
    );

    assign count_value   = st_r.count;
    assign enable_status = st_r.on;
    assign period_match  = st_r.match;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_sw_gate_stop: assert property ( // RQ1
        (cfg.mode == `HLT_M_SW_GATE) && !st_r.on |=> $stable(count_value))
        else $error("count moved with enable clear in software gate mode");

    a_gate_hi_stop: assert property ( // RQ2
        (cfg.mode == `HLT_M_GATE_HI) && !ext_s |=> $stable(count_value))
        else $error("count moved with gate low in active-high gate mode");

    a_gate_lo_stop: assert property ( // RQ3
        (cfg.mode == `HLT_M_GATE_LO) && ext_s |=> $stable(count_value))
        else $error("count moved with gate high in active-low gate mode");

    a_any_edge_clr: assert property ( // RQ4
        (cfg.mode == `HLT_M_RST_ANY) && st_r.on && (rise || fall)
        |=> count_value == `HLT_CNT_ZERO)
        else $error("edge did not clear the count");

    a_low_lvl_hold: assert property ( // RQ6
        (cfg.mode == `HLT_M_RST_LOW) && !ext_s |=> count_value == `HLT_CNT_ZERO)
        else $error("count not held at low reset level");

    a_oneshot_end: assert property ( // RQ12
        one_shot && match && !lvl_rst && !on_set
        |=> !enable_status && count_value == `HLT_CNT_ZERO ##1 $stable(count_value))
        else $error("one-shot did not stop and clear enable after match");

    a_mono_keep_on: assert property ( // RQ14
        mono && match && !on_clr |=> enable_status && count_value == `HLT_CNT_ZERO)
        else $error("monostable lost enable or count after match");

    a_reserved_idle: assert property ( // RQ20
        rsv |=> $stable(count_value) && !st_r.run)
        else $error("reserved mode moved the counter");

    a_pwm_no_rearm: assert property ( // RQ19
        lvl_pwm && match && !pwm_out && !rise && !fall |=> ##1 !pwm_out)
        else $error("pulse output set again on period match");

    a_rise_edge_clr: assert property ( // RQ5
        (cfg.mode == `HLT_M_RST_RISE) && st_r.on && rise |=> count_value == `HLT_CNT_ZERO)
        else $error("rising edge did not clear the count");

    a_fall_edge_clr: assert property ( // RQ5
        (cfg.mode == `HLT_M_RST_FALL) && st_r.on && fall |=> count_value == `HLT_CNT_ZERO)
        else $error("falling edge did not clear the count");

    a_high_lvl_hold: assert property ( // RQ6
        (cfg.mode == `HLT_M_RST_HIGH) && ext_s |=> count_value == `HLT_CNT_ZERO)
        else $error("count not held at high reset level");

    a_rr_edge_clr: assert property ( // RQ9
        (cfg.mode == `HLT_M_OS_RR) && st_r.on && st_r.run && rise
        |=> count_value == `HLT_CNT_ZERO)
        else $error("later rising edge did not clear the one-shot count");

    a_ff_edge_clr: assert property ( // RQ10
        (cfg.mode == `HLT_M_OS_FF) && st_r.on && st_r.run && fall
        |=> count_value == `HLT_CNT_ZERO)
        else $error("later falling edge did not clear the one-shot count");

    a_lvl_os_hold: assert property ( // RQ11
        ((cfg.mode == `HLT_M_OS_RLOW) && !ext_s) || ((cfg.mode == `HLT_M_OS_FHIGH) && ext_s)
        |=> count_value == `HLT_CNT_ZERO && !st_r.run)
        else $error("one-shot not held at its reset level");

    a_mono_start: assert property ( // RQ13
        mono && st_r.on && !st_r.run && start |=> st_r.run)
        else $error("monostable did not start on its edge");

    a_lv_opp_hold: assert property ( // RQ15
        ((cfg.mode == `HLT_M_LV_HIGH) && !ext_s) || ((cfg.mode == `HLT_M_LV_LOW) && ext_s)
        |=> count_value == `HLT_CNT_ZERO)
        else $error("level one-shot not held at the opposite level");

    a_fresh_edge_need: assert property ( // RQ16
        (cfg.mode inside {[`HLT_M_OS_RISE:`HLT_M_OS_FHIGH], [`HLT_M_MS_RISE:`HLT_M_MS_ANY]})
        && !st_r.run && !rise && !fall |=> !st_r.run)
        else $error("edge-started timer ran without a fresh edge");

    a_pwm_start_set: assert property ( // RQ17
        lvl_pwm && cfg.pwm_en && start && st_r.on && !st_r.run && !lvl_rst |=> pwm_out)
        else $error("pulse output not set on the starting edge");

    a_pwm_cmp_clr: assert property ( // RQ18
        cfg.pwm_en && !pwm_set && (count_value == cfg.pulse_width_compare) |=> !pwm_out)
        else $error("pulse output not cleared at the compare value");

endmodule // hlt_timer

// ===== hlt_timer_tb.sv
// self-checking bench for the timer mode control
// assumes hlt_pkg and hlt_params.svh; assertions live in the design
`include "hlt_params.svh"

module hlt_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    hlt_pkg::hlt_cfg_t cfg = '0;
    logic              on_set = 1'b0;
    logic              on_clr = 1'b0;
    logic              ext_lvl = 1'b0;
    logic              ext_reset_signal;
    hlt_pkg::hlt_cnt_t count_value;
    logic              enable_status;
    logic              period_match;
    logic              pwm_out;
    int                err_count = 0;
    int                compares = 0;

    always #2.5 clk = ~clk;

    hlt_ext_src ext_src (.clk(clk), .lvl(ext_lvl), .ext_reset_signal(ext_reset_signal));

    hlt_timer DUT (
        .clk              (clk),
        .rst              (rst),
        .cfg              (cfg),
        .on_set           (on_set),
        .on_clr           (on_clr),
        .ext_reset_signal (ext_reset_signal),
        .count_value      (count_value),
        .enable_status    (enable_status),
        .period_match     (period_match),
        .pwm_out          (pwm_out)
    );

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic set_on();
        on_set = 1'b1;
        cyc(1);
        on_set = 1'b0;
    endtask

    // reset, settle the synchroniser, then enable
    task automatic start(input logic [4:0] m, input logic [7:0] per, input logic lvl,
                         input logic pe);
        cfg = '{mode: m, period_value: per, pulse_width_compare: 8'h02, pwm_en: pe};
        ext_lvl = lvl;
        rst = 1'b1;
        cyc(4);
        rst = 1'b0;
        cyc(6);
        set_on();
    endtask

    task automatic wait_match();
        int k;
        k = 0;
        while (period_match !== 1'b1 && k < 40) begin
            cyc(1);
            k++;
        end
        chk("match", {7'h00, period_match}, 8'h01);
    endtask

    task automatic s_sw_gate();
        start(`HLT_M_SW_GATE, 8'h03, 1'b0, 1'b0);
        chk("en", {7'h00, enable_status}, 8'h01);
        for (int i = 1; i <= 4; i++) begin
            cyc(1);
            chk("cnt", count_value, 8'(i % 4));
            chk("pm", {7'h00, period_match}, {7'h00, i == 4});
        end
        on_clr = 1'b1;
        cyc(1);
        on_clr = 1'b0;
        cyc(3);
        chk("cnt_hold", count_value, 8'h01);
        chk("en_off", {7'h00, enable_status}, 8'h00);
    endtask

    task automatic s_one_shot();
        start(`HLT_M_OS_SW, 8'h02, 1'b0, 1'b0);
        cyc(2);
        chk("cnt", count_value, 8'h01);
        cyc(1);
        chk("cnt", count_value, 8'h02);
        cyc(1);
        chk("cnt0", count_value, 8'h00);
        chk("en0", {7'h00, enable_status}, 8'h00);
        cyc(4);
        chk("cnt_stop", count_value, 8'h00);
    endtask

    task automatic s_reserved();
        logic [4:0] m[5] = '{5'h10, 5'h14, 5'h15, 5'h18, 5'h1F};
        foreach (m[i]) begin
            start(m[i], 8'h04, 1'b0, 1'b0);
            ext_lvl = 1'b1;
            cyc(5);
            ext_lvl = 1'b0;
            cyc(5);
            chk("rsv_cnt", count_value, 8'h00);
        end
    endtask

    task automatic s_gate_level();
        logic [4:0] m[4] = '{`HLT_M_GATE_HI, `HLT_M_GATE_LO, `HLT_M_RST_LOW, `HLT_M_RST_HIGH};
        logic       p[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        foreach (m[i]) begin
            start(m[i], 8'hFF, p[i], 1'b0);
            cyc(6);
            chk("held", count_value, 8'h00);
            ext_lvl = ~p[i];
            cyc(10);
            chk("runs", {7'h00, count_value inside {[8'h04:8'h0A]}}, 8'h01);
            ext_lvl = p[i];
            cyc(20);
            if (i < 2) begin
                chk("gated", {7'h00, count_value inside {[8'h07:8'h0E]}}, 8'h01);
            end else begin
                chk("lvl_rst", count_value, 8'h00);
            end
        end
    endtask

    task automatic s_edge_reset();
        logic [4:0] m[3] = '{`HLT_M_RST_ANY, `HLT_M_RST_RISE, `HLT_M_RST_FALL};
        logic       idle[3] = '{1'b0, 1'b0, 1'b1};
        foreach (m[i]) begin
            start(m[i], 8'hFF, idle[i], 1'b0);
            cyc(20);
            ext_lvl = ~idle[i];
            cyc(6);
            chk("edge_clr", {7'h00, count_value < 8'h08}, 8'h01);
            cyc(10);
            ext_lvl = idle[i];
            cyc(6);
            chk("back_edge", {7'h00, count_value < 8'h08}, {7'h00, i == 0});
        end
    endtask

    task automatic s_edge_start();
        logic [4:0] m[6] = '{5'h09, 5'h0A, 5'h0B, 5'h11, 5'h12, 5'h13};
        logic       idle[6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
        foreach (m[i]) begin
            start(m[i], 8'h04, idle[i], 1'b0);
            cyc(8);
            chk("no_edge", count_value, 8'h00);
            ext_lvl = ~idle[i];
            wait_match();
            chk("en_after", {7'h00, enable_status}, {7'h00, m[i][4]});
            cyc(3);
            chk("stop0", count_value, 8'h00);
            if (!m[i][4]) begin
                set_on();
                cyc(8);
                chk("fresh", count_value, 8'h00);
            end
            ext_lvl = idle[i];
            cyc(6);
            ext_lvl = ~idle[i];
            wait_match();
        end
    endtask

    task automatic s_level_pwm();
        logic [4:0] m[4] = '{`HLT_M_OS_RLOW, `HLT_M_OS_FHIGH, `HLT_M_LV_HIGH, `HLT_M_LV_LOW};
        logic       idle[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        int         k;
        foreach (m[i]) begin
            start(m[i], 8'h06, idle[i], 1'b1);
            cyc(8);
            chk("lvl_held", count_value, 8'h00);
            ext_lvl = ~idle[i];
            if (i < 2) begin
                k = 0;
                while (pwm_out !== 1'b1 && k < 12) begin
                    cyc(1);
                    k++;
                end
                chk("pwm_on", {7'h00, pwm_out}, 8'h01);
                chk("pwm_early", {7'h00, count_value < 8'h02}, 8'h01);
            end
            wait_match();
            chk("os_en", {7'h00, enable_status}, 8'h00);
            if (i < 2) begin
                chk("pwm_off", {7'h00, pwm_out}, 8'h00);
                cyc(3);
                chk("pwm_stay", {7'h00, pwm_out}, 8'h00);
            end
        end
    endtask

    task automatic s_edge_restart();
        logic [4:0] m[2] = '{`HLT_M_OS_RR, `HLT_M_OS_FF};
        logic       idle[2] = '{1'b0, 1'b1};
        foreach (m[i]) begin
            start(m[i], 8'h10, idle[i], 1'b0);
            cyc(4);
            ext_lvl = ~idle[i];
            cyc(10);
            ext_lvl = idle[i];
            cyc(6);
            chk("rr_keep", count_value, 8'h0C);
            ext_lvl = ~idle[i];
            cyc(6);
            chk("rr_clr", count_value, 8'h02);
            wait_match();
            chk("rr_en", {7'h00, enable_status}, 8'h00);
        end
    endtask

    initial begin
        cyc(4);
        s_sw_gate();
        s_one_shot();
        s_reserved();
        s_gate_level();
        s_edge_reset();
        s_edge_start();
        s_edge_restart();
        s_level_pwm();
        report_and_stop();
    end

    // watchdog at 40000 cycles, well beyond the thousand or so the tests need
    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end
endmodule // hlt_timer_tb
